/* File: hw/rf_synth_config_registers.sv */
// design: apb register bank holding the synthesiser, bias, power and loop configuration
`timescale 1ns/10ps

module rf_synth_config_registers (
	input  wire logic                         clock,
	input  wire logic                         rst_b,
	input  wire logic                         clock_enable,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [31:0]                  paddr,
	input  wire logic [31:0]                  pwdata,
	input  wire logic [3:0]                   pstrb,
	input  wire rf_synth_pkg::loop_sense_t    loop_sense,
	output logic [31:0]                       prdata,
	output logic                              pready,
	output logic                              pslverr,
	output rf_synth_pkg::synth_setting_t      setting,
	output logic                              irq
);
	import rf_synth_pkg::*;

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	// main register: soft reset control and word select
	logic [7:0]           main_reg;
	// frequency words, high/mid/low byte each, and the 11-bit separation
	logic [7:0]           freq_word_a_high, freq_word_a_mid, freq_word_a_low;
	logic [7:0]           freq_word_b_high, freq_word_b_mid, freq_word_b_low;
	logic [2:0]           sep_high;
	logic [7:0]           sep_low;
	// bias currents, oscillator source and amplifier array levels
	logic [3:0]           core_current;
	logic [1:0]           buffer_drive;
	logic                 bypass;
	logic [3:0]           high_array, low_array;
	// loop filter, divider, alarm switch and the loop-break test control
	logic                 filter_sel;
	logic [3:0]           ref_div;
	logic                 alarm_disable;
	logic                 break_loop;
	logic                 sampled_compare;
	// interrupt state; the _q flops keep the last alarm levels for edge detection
	logic [IRQ_WIDTH-1:0] irq_status, irq_mask;
	logic                 alarm_high_q, alarm_low_q;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	// decoded transfer and the byte it carries
	logic       access;
	logic       wr;
	logic [7:0] index;
	logic       mapped;
	logic [7:0] wbyte;
	logic       soft_reset;
	logic       sample_event;
	logic [IRQ_WIDTH-1:0] irq_events;
	logic [7:0] next_rdata;

	// access is taken in the first cycle of the access phase; pready rises the cycle after
	// the ~pready term keeps a held access phase from being taken twice
	// while the master still sits on it sampling the answer
	assign access = psel & penable & ~pready & clock_enable;
	// a write without the low byte lane completes but changes nothing
	assign wr     = access & pwrite & pstrb[0];
	assign index  = paddr[9:2];
	assign wbyte  = pwdata[7:0];
	// registers answer only with the upper address bits clear; paddr[1:0] is not decoded, so the four byte offsets alias
	assign mapped = (paddr[31:10] == 22'h0) && (index <= IDX_LOOP || index == IDX_IRQ_STATUS
		|| index == IDX_IRQ_MASK || index == IDX_TEST_CTRL);

	// soft reset is level-held while main bit 0 sits low
	// main itself is left alone, otherwise the host could never leave soft reset
	assign soft_reset = ~main_reg[MAIN_SOFT_RESET_BIT];

	// falling write on the filter bit while the loop is broken
	// the old filter bit must be 1, so rewriting 0 over 0 samples nothing
	assign sample_event = wr && mapped && index == IDX_LOOP && break_loop
		&& filter_sel && !wbyte[LOOP_FILTER_BIT];

	// rising edges of the alarms count as events only while enabled
	// an alarm already high when enabled gives no event until it drops and returns
	assign irq_events[IRQ_ALARM_HIGH_BIT] = loop_sense.alarm_high & ~alarm_high_q & ~alarm_disable;
	assign irq_events[IRQ_ALARM_LOW_BIT]  = loop_sense.alarm_low & ~alarm_low_q & ~alarm_disable;
	assign irq_events[IRQ_SAMPLE_BIT]     = sample_event;

	// ----------------------------------------------------------------
	// main register: never touched by soft reset
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			main_reg <= RST_MAIN;
		// bit 0 written low starts the soft reset, written high ends it
		end else if (wr && mapped && index == IDX_MAIN) begin
			main_reg <= wbyte & 8'h5f; // bits 7 and 5 unused
		end
	end

	// ----------------------------------------------------------------
	// frequency words and separation
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			freq_word_a_high <= RST_FREQ_WORD_A_HIGH;
			freq_word_a_mid  <= RST_FREQ_WORD_A_MID;
			freq_word_a_low  <= RST_FREQ_WORD_A_LOW;
			freq_word_b_high <= RST_FREQ_WORD_B_HIGH;
			freq_word_b_mid  <= RST_FREQ_WORD_B_MID;
			freq_word_b_low  <= RST_FREQ_WORD_B_LOW;
			sep_high    <= RST_SEP_HIGH;
			sep_low     <= RST_SEP_LOW;
		// defaults are forced every cycle while soft reset holds, so writes
		// made in that time are lost rather than queued
		end else if (clock_enable && soft_reset) begin
			freq_word_a_high <= RST_FREQ_WORD_A_HIGH;
			freq_word_a_mid  <= RST_FREQ_WORD_A_MID;
			freq_word_a_low  <= RST_FREQ_WORD_A_LOW;
			freq_word_b_high <= RST_FREQ_WORD_B_HIGH;
			freq_word_b_mid  <= RST_FREQ_WORD_B_MID;
			freq_word_b_low  <= RST_FREQ_WORD_B_LOW;
			sep_high    <= RST_SEP_HIGH;
			sep_low     <= RST_SEP_LOW;
		end else if (wr && mapped) begin
			case (index)
				// bytes land one at a time: the active word passes through mixed values
				IDX_FREQ_WORD_A_HIGH: freq_word_a_high <= wbyte;
				IDX_FREQ_WORD_A_MID:  freq_word_a_mid  <= wbyte;
				IDX_FREQ_WORD_A_LOW:  freq_word_a_low  <= wbyte;
				IDX_FREQ_WORD_B_HIGH: freq_word_b_high <= wbyte;
				IDX_FREQ_WORD_B_MID:  freq_word_b_mid  <= wbyte;
				IDX_FREQ_WORD_B_LOW:  freq_word_b_low  <= wbyte;
				IDX_SEP_HIGH:    sep_high    <= wbyte[2:0];
				IDX_SEP_LOW:     sep_low     <= wbyte;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// bias, oscillator and amplifier power
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			core_current <= RST_CORE_CURRENT;
			buffer_drive <= RST_BUFFER_DRIVE;
			bypass       <= RST_BYPASS;
			high_array   <= RST_HIGH_ARRAY;
			low_array    <= RST_LOW_ARRAY;
		end else if (clock_enable && soft_reset) begin
			core_current <= RST_CORE_CURRENT;
			buffer_drive <= RST_BUFFER_DRIVE;
			bypass       <= RST_BYPASS;
			high_array   <= RST_HIGH_ARRAY;
			low_array    <= RST_LOW_ARRAY;
		end else if (wr && mapped) begin
			case (index)
				// bits 3:2 are not stored at all, so they cannot read back as one
				IDX_BIAS: begin
					core_current <= wbyte[BIAS_CORE_LSB +: 4];
					buffer_drive <= wbyte[1:0]; // host picks the code
				end
				// setting the bypass stops the crystal; an external clock must already run
				IDX_OSC: bypass <= wbyte[0];
				// both array levels come from one write, so they never disagree for a cycle
				IDX_POWER: begin
					high_array <= wbyte[POWER_HIGH_LSB +: 4];
					low_array  <= wbyte[3:0];
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// loop control and loop-break test control
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			filter_sel    <= RST_FILTER_SEL;
			ref_div       <= RST_REF_DIVIDER;
			alarm_disable <= RST_ALARM_DISABLE;
			break_loop    <= 1'b0;
		end else if (clock_enable && soft_reset) begin
			filter_sel    <= RST_FILTER_SEL;
			ref_div       <= RST_REF_DIVIDER;
			alarm_disable <= RST_ALARM_DISABLE;
			break_loop    <= 1'b0;
		end else if (wr && mapped) begin
			case (index)
				IDX_LOOP: begin
					filter_sel    <= wbyte[LOOP_FILTER_BIT];
					// divide codes 0 and 1 are stored as written; avoiding them is the host's job
					ref_div       <= wbyte[LOOP_DIVIDER_LSB +: 4]; // codes 0,1 left to host
					alarm_disable <= wbyte[LOOP_ALARM_DIS_BIT];
					// bits 1:0 are live alarm status and take no write
				end
				// loop-break test control; soft reset clears it with the rest
				IDX_TEST_CTRL: break_loop <= wbyte[TEST_BREAK_LOOP_BIT];
				default: ;
			endcase
		end
	end

	// captured comparator level; holds until the next qualifying write
	// the event already carries clock_enable through the write strobe
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sampled_compare <= 1'b0;
		end else if (sample_event) begin
			sampled_compare <= loop_sense.freq_compare;
		end
	end

	// ----------------------------------------------------------------
	// interrupts: sticky status, write one to clear, set wins
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			alarm_high_q <= 1'b0;
			alarm_low_q  <= 1'b0;
			irq_status   <= '0;
			irq_mask     <= '0;
		end else if (clock_enable) begin
			// edge history runs even while disabled, so enabling never fakes an edge
			alarm_high_q <= loop_sense.alarm_high;
			alarm_low_q  <= loop_sense.alarm_low;
			if (wr && mapped && index == IDX_IRQ_MASK) begin
				irq_mask <= wbyte[IRQ_WIDTH-1:0];
			end
			// an event in the clearing cycle survives: set beats clear, nothing is lost
			if (wr && mapped && index == IDX_IRQ_STATUS) begin
				irq_status <= (irq_status & ~wbyte[IRQ_WIDTH-1:0]) | irq_events;
			end else begin
				irq_status <= irq_status | irq_events;
			end
		end
	end

	// the interrupt output lags status and mask by one clock; it comes from a flop
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else if (clock_enable) begin
			irq <= |(irq_status & irq_mask);
		end
	end

	// ----------------------------------------------------------------
	// read mux; unused positions read zero
	// ----------------------------------------------------------------
	always_comb begin
		next_rdata = 8'h00;
		case (index)
			IDX_MAIN:        next_rdata = main_reg;
			IDX_FREQ_WORD_A_HIGH: next_rdata = freq_word_a_high;
			IDX_FREQ_WORD_A_MID:  next_rdata = freq_word_a_mid;
			IDX_FREQ_WORD_A_LOW:  next_rdata = freq_word_a_low;
			IDX_FREQ_WORD_B_HIGH: next_rdata = freq_word_b_high;
			IDX_FREQ_WORD_B_MID:  next_rdata = freq_word_b_mid;
			IDX_FREQ_WORD_B_LOW:  next_rdata = freq_word_b_low;
			IDX_SEP_HIGH:    next_rdata = {5'h00, sep_high};
			IDX_SEP_LOW:     next_rdata = sep_low;
			IDX_BIAS:        next_rdata = {core_current, 2'h0, buffer_drive};
			IDX_OSC:         next_rdata = {7'h00, bypass};
			IDX_POWER:       next_rdata = {high_array, low_array};
			// alarm status is live and masked by the disable bit
			IDX_LOOP:        next_rdata = {filter_sel, ref_div, alarm_disable,
				loop_sense.alarm_high & ~alarm_disable,
				loop_sense.alarm_low & ~alarm_disable};
			// interrupt and test registers sit above the synthesiser block
			IDX_IRQ_STATUS:  next_rdata = {5'h00, irq_status};
			IDX_IRQ_MASK:    next_rdata = {5'h00, irq_mask};
			IDX_TEST_CTRL:   next_rdata = {6'h00, sampled_compare, break_loop};
			default:         next_rdata = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// apb answer: one wait state, registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (clock_enable) begin
			pready  <= access;
			// refused transfers still complete, flagged by the error pulse
			pslverr <= access & ~mapped;
			// read data is captured only on a read, so it stands until the next one
			if (access && !pwrite && mapped) begin
				prdata <= {24'h00_0000, next_rdata};
			end else if (access && !pwrite) begin
				// a refused read returns zero whatever the low index decodes to
				prdata <= 32'h0000_0000;
			end
		end
	end

	// ----------------------------------------------------------------
	// settings to the analog side; word select lives in main
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			// everything reads zero until the first edge after reset release
			setting <= '0;
		end else if (clock_enable) begin
			setting.active_word        <= main_reg[MAIN_FREQ_SELECT_BIT]
				? {freq_word_b_high, freq_word_b_mid, freq_word_b_low} : {freq_word_a_high, freq_word_a_mid, freq_word_a_low};
			// a word select change switches the whole word in one registered step; byte writes still reach it one at a time
			setting.separation         <= {sep_high, sep_low};
			setting.osc_core_current   <= core_current;
			setting.amp_buffer_drive   <= buffer_drive;
			setting.crystal_bypass     <= bypass;
			setting.high_array_level   <= high_array;
			setting.low_array_level    <= low_array;
			setting.loop_filter_select <= filter_sel;
			setting.ref_divider        <= ref_div;
			// the analog side wants an enable, the register holds a disable
			setting.alarm_enable       <= ~alarm_disable;
		end
	end

endmodule // rf_synth_config_registers

/* File: shared/rf_synth_pkg.sv */
// package: register map, reset values and field layout of the synthesiser configuration slice
package rf_synth_pkg;

	// ----------------------------------------------------------------
	// register word indices (times four for the byte address on the bus)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_MAIN           = 8'h00;
	localparam logic [7:0] IDX_FREQ_WORD_A_HIGH    = 8'h01;
	localparam logic [7:0] IDX_FREQ_WORD_A_MID     = 8'h02;
	localparam logic [7:0] IDX_FREQ_WORD_A_LOW     = 8'h03;
	localparam logic [7:0] IDX_FREQ_WORD_B_HIGH    = 8'h04;
	localparam logic [7:0] IDX_FREQ_WORD_B_MID     = 8'h05;
	localparam logic [7:0] IDX_FREQ_WORD_B_LOW     = 8'h06;
	localparam logic [7:0] IDX_SEP_HIGH       = 8'h07;
	localparam logic [7:0] IDX_SEP_LOW        = 8'h08;
	localparam logic [7:0] IDX_BIAS           = 8'h09;
	localparam logic [7:0] IDX_OSC            = 8'h0a;
	localparam logic [7:0] IDX_POWER          = 8'h0b;
	localparam logic [7:0] IDX_LOOP           = 8'h0c;
	localparam logic [7:0] IDX_IRQ_STATUS     = 8'h10;
	localparam logic [7:0] IDX_IRQ_MASK       = 8'h11;
	localparam logic [7:0] IDX_TEST_CTRL      = 8'h12;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_FREQ_WORD_A_HIGH    = 8'h75;
	localparam logic [7:0] RST_FREQ_WORD_A_MID     = 8'ha0;
	localparam logic [7:0] RST_FREQ_WORD_A_LOW     = 8'hcb;
	localparam logic [7:0] RST_FREQ_WORD_B_HIGH    = 8'h75;
	localparam logic [7:0] RST_FREQ_WORD_B_MID     = 8'ha5;
	localparam logic [7:0] RST_FREQ_WORD_B_LOW     = 8'h4e;
	localparam logic [2:0] RST_SEP_HIGH       = 3'h0;
	localparam logic [7:0] RST_SEP_LOW        = 8'h59;
	localparam logic [3:0] RST_CORE_CURRENT   = 4'hc;
	localparam logic [1:0] RST_BUFFER_DRIVE   = 2'h2;
	localparam logic [0:0] RST_BYPASS         = 1'h0;
	localparam logic [3:0] RST_HIGH_ARRAY     = 4'h0;
	localparam logic [3:0] RST_LOW_ARRAY      = 4'hf;
	localparam logic [0:0] RST_FILTER_SEL     = 1'h0;
	localparam logic [3:0] RST_REF_DIVIDER    = 4'h2;
	localparam logic [0:0] RST_ALARM_DISABLE  = 1'h0;
	localparam logic [7:0] RST_MAIN           = 8'h01;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int MAIN_SOFT_RESET_BIT   = 0;
	localparam int MAIN_FREQ_SELECT_BIT  = 6;
	localparam int BIAS_CORE_LSB         = 4;
	localparam int POWER_HIGH_LSB        = 4;
	localparam int LOOP_FILTER_BIT       = 7;
	localparam int LOOP_DIVIDER_LSB      = 3;
	localparam int LOOP_ALARM_DIS_BIT    = 2;
	localparam int LOOP_ALARM_HIGH_BIT   = 1;
	localparam int LOOP_ALARM_LOW_BIT    = 0;
	localparam int TEST_BREAK_LOOP_BIT   = 0;
	localparam int TEST_SAMPLE_BIT       = 1;
	// interrupt status/mask layout
	localparam int IRQ_ALARM_HIGH_BIT    = 0;
	localparam int IRQ_ALARM_LOW_BIT     = 1;
	localparam int IRQ_SAMPLE_BIT        = 2;
	localparam int IRQ_WIDTH             = 3;

	// ----------------------------------------------------------------
	// grouped outputs towards the analog front end
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [23:0] active_word;
		logic [10:0] separation;
		logic [3:0]  osc_core_current;
		logic [1:0]  amp_buffer_drive;
		logic        crystal_bypass;
		logic [3:0]  high_array_level;
		logic [3:0]  low_array_level;
		logic        loop_filter_select;
		logic [3:0]  ref_divider;
		logic        alarm_enable;
	} synth_setting_t;

	typedef struct packed {
		logic alarm_high;
		logic alarm_low;
		logic freq_compare;
	} loop_sense_t;

endpackage

/* File: testbench/rf_synth_config_checker_assertions.sv */
// checker: port-level relations of the synthesiser configuration register bank
`timescale 1ns/10ps
module rf_synth_config_checker
	import rf_synth_pkg::*;
(
	input  wire logic                      clock,
	input  wire logic                      rst_b,
	input  wire logic                      clock_enable,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [31:0]               paddr,
	input  wire rf_synth_pkg::loop_sense_t loop_sense,
	input  wire logic [31:0]               prdata,
	input  wire logic                      pready,
	input  wire logic                      pslverr
);
	// ----------------------------------------
	// read answers and handshake
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	logic rd_ok;
	// a completed read of a mapped register, address still held by the master
	assign rd_ok = pready && psel && !pwrite && !pslverr;

	a_sep_unused_zero: assert property (rd_ok && paddr[9:2] == IDX_SEP_HIGH |-> prdata[7:3] == 5'h00)
		else $error("separation high unused bits not zero");
	a_bias_unused_zero: assert property (rd_ok && paddr[9:2] == IDX_BIAS |-> prdata[3:2] == 2'h0)
		else $error("bias unused bits not zero");
	a_osc_unused_zero: assert property (rd_ok && paddr[9:2] == IDX_OSC |-> prdata[7:1] == 7'h00)
		else $error("oscillator unused bits not zero");
	a_alarm_high_live: assert property (rd_ok && paddr[9:2] == IDX_LOOP |->
		prdata[1] == ($past(loop_sense.alarm_high) && !prdata[2]))
		else $error("high alarm bit wrong");
	a_alarm_low_live: assert property (rd_ok && paddr[9:2] == IDX_LOOP |->
		prdata[0] == ($past(loop_sense.alarm_low) && !prdata[2]))
		else $error("low alarm bit wrong");
	a_upper_lanes_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
		else $error("read data upper lanes not zero");
	a_ready_after_take: assert property (psel && penable && !pready && clock_enable |=> pready)
		else $error("no answer one cycle after access");
	a_ready_single_pulse: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	a_unmapped_refused: assert property (pready && !pwrite && paddr[9:2] inside {8'h0d, 8'h0e, 8'h0f}
		|-> pslverr && prdata == 32'h00000000)
		else $error("unmapped read not refused");
endmodule // rf_synth_config_checker

bind rf_synth_config_registers rf_synth_config_checker u_rf_synth_config_checker (
	.clock(clock), .rst_b(rst_b), .clock_enable(clock_enable), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .loop_sense(loop_sense), .prdata(prdata), .pready(pready),
	.pslverr(pslverr)
);

/* File: testbench/rf_synth_host_model.sv */
// partner model: host controller issuing register transfers on the apb port
`timescale 1ns/10ps
module rf_synth_host_model (
	input  wire logic        clock,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [31:0]      paddr,
	output logic [31:0]      pwdata,
	output logic [3:0]       pstrb,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// ----------------------------------------
	// transfer engine
	// ----------------------------------------
	// idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h00000000;
		pwdata = 32'h00000000;
		pstrb = 4'h0;
	end

	// setup, access, then hold until ready; only the bench watchdog ends a wait on a dead slave
	task automatic access(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		output logic [7:0] rd, output logic err);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {22'h000000, idx, 2'b00};
		pwdata <= {24'h000000, wd};
		pstrb <= 4'hf;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines must not keep showing the last request
		paddr <= ~paddr;
		pwdata <= ~pwdata;
		pstrb <= 4'h0;
	endtask
endmodule // rf_synth_host_model

/* File: testbench/rf_synth_config_registers_tb_top.sv */
// testbench: register map, soft reset, alarms, interrupt and comparator sampling
`timescale 1ns/10ps
module rf_synth_config_registers_tb_top;
	import rf_synth_pkg::*;
	logic           clock = 1'b0;
	logic           rst_b = 1'b0;
	logic           clock_enable = 1'b1;
	logic           psel, penable, pwrite;
	logic [31:0]    paddr, pwdata, prdata;
	logic [3:0]     pstrb;
	loop_sense_t    loop_sense = '0;
	logic           pready, pslverr, irq;
	synth_setting_t setting;
	logic [7:0]     rd;
	logic           err;
	int             n_errors = 0;
	int             cmp_count = 0;
	logic [7:0]     dflt [1:12] = '{8'h75, 8'ha0, 8'hcb, 8'h75, 8'ha5, 8'h4e, 8'h00, 8'h59, 8'hc2, 8'h00, 8'h0f, 8'h10};
	logic [7:0]     wmask [1:12] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h07, 8'hff, 8'hf3, 8'h01, 8'hff, 8'hfc};
	logic [7:0]     pat [0:1] = '{8'hff, 8'h11};

	always #20 clock = ~clock;

	rf_synth_config_registers u_rf_synth_config_registers (.clock(clock), .rst_b(rst_b), .clock_enable(clock_enable),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.loop_sense(loop_sense), .prdata(prdata), .pready(pready), .pslverr(pslverr), .setting(setting), .irq(irq));
	rf_synth_host_model u_rf_synth_host_model (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		u_rf_synth_host_model.access(1'b1, idx, d, rd, err);
	endtask
	// read data and error flag compared together
	task automatic rdchk(input logic [7:0] idx, input logic [8:0] exp);
		u_rf_synth_host_model.access(1'b0, idx, 8'h00, rd, err);
		check($sformatf("register %h", idx), {23'h0, exp}, {23'h0, err, rd});
	endtask
	task automatic results();
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		for (int i = 1; i <= 6; i++) rdchk(8'(i), {1'b0, dflt[i]});
		for (int i = 7; i <= 9; i++) rdchk(8'(i), {1'b0, dflt[i]});
		for (int i = 10; i <= 12; i++) rdchk(8'(i), {1'b0, dflt[i]});
		check("word", 24'h75a0cb, setting.active_word);
		check("separation", 11'h059, setting.separation);
		check("low array", 4'hf, setting.low_array_level);
		// drive 11 then 01, as for carriers above and below 500 MHz; divider never below 2
		for (int p = 0; p < 2; p++) begin
			for (int i = 1; i <= 12; i++) wr(8'(i), pat[p]);
			for (int i = 1; i <= 12; i++) rdchk(8'(i), {1'b0, pat[p] & wmask[i]});
			if (p == 0) begin
				check("drive", 2'h3, setting.amp_buffer_drive);
				check("core", 4'hf, setting.osc_core_current);
				check("bypass", 1'b1, setting.crystal_bypass);
				check("high array", 4'hf, setting.high_array_level);
				check("filter", 1'b1, setting.loop_filter_select);
				check("divider", 4'hf, setting.ref_divider);
				check("alarm on", 1'b0, setting.alarm_enable);
				check("separation", 11'h7ff, setting.separation);
			end
		end
		// word select follows main bit 6, soft reset bit kept high
		wr(8'h04, 8'h5a);
		wr(8'h00, 8'h41);
		repeat (2) @(posedge clock);
		check("word b", 24'h5a1111, setting.active_word);
		wr(8'h00, 8'h01);
		repeat (2) @(posedge clock);
		check("word a", 24'h111111, setting.active_word);
		// soft reset: defaults return and writes are lost until the bit is set again
		wr(8'h00, 8'h00);
		rdchk(8'h01, 9'h075);
		wr(8'h01, 8'h33);
		rdchk(8'h01, 9'h075);
		wr(8'h00, 8'h01);
		rdchk(8'h04, 9'h075);
		wr(8'h01, 8'h33);
		rdchk(8'h01, 9'h033);
		rdchk(8'h0d, 9'h100);
		wr(8'h0f, 8'h55);
		check("write refused", 1'b1, err);
		// alarms, masking and clearing of the interrupt
		loop_sense.alarm_high <= 1'b1;
		loop_sense.alarm_low <= 1'b1;
		repeat (2) @(posedge clock);
		rdchk(8'h0c, 9'h013);
		check("irq masked", 1'b0, irq);
		rdchk(8'h10, 9'h003);
		wr(8'h11, 8'h01);
		repeat (2) @(posedge clock);
		check("irq raised", 1'b1, irq);
		wr(8'h10, 8'h01);
		repeat (2) @(posedge clock);
		check("irq cleared", 1'b0, irq);
		rdchk(8'h10, 9'h002);
		wr(8'h0c, 8'h14);
		rdchk(8'h0c, 9'h014);
		loop_sense <= '0;
		// falling filter bit with loop break captures the comparator
		wr(8'h12, 8'h01);
		wr(8'h0c, 8'h90);
		loop_sense.freq_compare <= 1'b1;
		wr(8'h0c, 8'h10);
		rdchk(8'h12, 9'h003);
		rdchk(8'h10, 9'h006);
		// with the clock enable low an alarm edge leaves no trace
		wr(8'h10, 8'h06);
		rdchk(8'h10, 9'h000);
		clock_enable <= 1'b0;
		loop_sense.alarm_low <= 1'b1;
		repeat (3) @(posedge clock);
		loop_sense.alarm_low <= 1'b0;
		@(posedge clock);
		clock_enable <= 1'b1;
		rdchk(8'h10, 9'h000);
		results();
	end

	// watchdog well beyond the fewer than a hundred transfers above
	initial begin
		repeat (5000) @(posedge clock);
		n_errors++;
		results();
	end
endmodule // rf_synth_config_registers_tb_top
